// File: rtl/acm_top.sv
// Local design decision: register access over AXI4-Lite.
`timescale 1ns/10ps
// Converter operation control register with AXI4-Lite access
module acm_top (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // AXI4-Lite write address
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // AXI4-Lite write data
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read address
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    // AXI4-Lite read data
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Converter side events
    input wire logic filter_output,
    input wire logic channel_switch,
    input wire logic multi_channel,
    // Converter controls
    output logic filter_reset,
    output logic conversion_start,
    output logic data_ready,
    output logic reference_output_pin_en,
    output logic [2:0] operating_mode,
    output logic processing_hold,
    output logic osc_enable,
    output logic crystal_or_clock_pin_out_en,
    output logic ext_clk_en,
    output logic crystal_input_pin_en
);
    typedef struct packed {
        logic aw_got;
        logic [7:0] aw_addr;
        logic w_got;
        logic [31:0] w_data;
        logic [3:0] w_strb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic [15:0] ctrl;
        logic filt_rst;
        logic conv_start;
        logic ready;
        logic [1:0] settle_cnt;
        logic [2:0] mode_out;
        logic ref_en;
    } acm_state_type;
    acm_state_type s_q, s_d;

    logic wr_fire;
    logic wr_hit;
    logic delay_busy;
    logic [15:0] merged;
    logic [2:0] delay_code;
    logic settled_only;

    assign delay_code = s_q.ctrl[acm_pkg::DELAY_LSB +: 3];
    assign settled_only = s_q.ctrl[acm_pkg::SETTLED_BIT];
    assign wr_fire = s_q.aw_got && s_q.w_got && !s_q.bvalid;
    assign wr_hit = wr_fire && (s_q.aw_addr == acm_pkg::CTRL_ADDR);

    // Byte lanes merge into the register; reserved bits never store
    always_comb begin
        merged = s_q.ctrl;
        if (s_q.w_strb[0]) begin
            merged[7:0] = s_q.w_data[7:0];
        end
        if (s_q.w_strb[1]) begin
            merged[15:8] = s_q.w_data[15:8];
        end
        merged = merged & acm_pkg::CTRL_WMASK;
    end

    // Bus handshakes, register update and converter sequencing
    always_comb begin
        s_d = s_q;
        s_d.filt_rst = 1'b0;
        s_d.conv_start = 1'b0;
        // Address and data may come in either order
        if (s_axi_awvalid && !s_q.aw_got) begin
            s_d.aw_got = 1'b1;
            s_d.aw_addr = {s_axi_awaddr[7:2], 2'b00};
        end
        if (s_axi_wvalid && !s_q.w_got) begin
            s_d.w_got = 1'b1;
            s_d.w_data = s_axi_wdata;
            s_d.w_strb = s_axi_wstrb;
        end
        if (wr_fire) begin
            s_d.aw_got = 1'b0;
            s_d.w_got = 1'b0;
            s_d.bvalid = 1'b1;
            if (wr_hit) begin
                s_d.bresp = acm_pkg::RESP_OKAY;
            end else if (s_q.aw_addr == acm_pkg::STAT_ADDR) begin
                s_d.bresp = acm_pkg::RESP_OKAY; // Status is read-only, write dropped
            end else begin
                s_d.bresp = acm_pkg::RESP_SLVERR;
            end
        end
        if (s_q.bvalid && s_axi_bready) begin
            s_d.bvalid = 1'b0;
        end
        // Any control register write, even identical data, restarts the converter
        if (wr_hit) begin
            s_d.ctrl = merged;
            s_d.filt_rst = 1'b1;
            s_d.conv_start = 1'b1;
            s_d.ready = 1'b0;
            s_d.settle_cnt = 2'b00;
        end else if (filter_output && !delay_busy && s_q.mode_out != 3'(acm_pkg::MODE_RESERVED)) begin
            // Settled output needs three filter outputs when one channel is live
            if (settled_only && !multi_channel && s_q.settle_cnt != 2'b10) begin
                s_d.settle_cnt = s_q.settle_cnt + 2'b01;
            end else begin
                s_d.ready = 1'b1;
                s_d.settle_cnt = 2'b00;
                // Single conversion drops to standby once done
                if (s_q.mode_out == 3'(acm_pkg::MODE_SINGLE)) begin
                    s_d.ctrl[acm_pkg::MODE_LSB +: 3] = 3'(acm_pkg::MODE_STANDBY);
                end
            end
        end
        if (channel_switch) begin
            s_d.settle_cnt = 2'b00;
        end
        s_d.mode_out = s_d.ctrl[acm_pkg::MODE_LSB +: 3];
        s_d.ref_en = s_d.ctrl[acm_pkg::REF_EN_BIT];
        // Reads answer one cycle after the address is taken
        if (s_axi_arvalid && !s_q.rvalid) begin
            s_d.rvalid = 1'b1;
            s_d.rresp = acm_pkg::RESP_OKAY;
            if ({s_axi_araddr[7:2], 2'b00} == acm_pkg::CTRL_ADDR) begin
                s_d.rdata = {16'h0000, s_d.ctrl};
            end else if ({s_axi_araddr[7:2], 2'b00} == acm_pkg::STAT_ADDR) begin
                s_d.rdata = {29'h00000000, delay_busy, s_q.filt_rst, s_q.ready};
            end else begin
                s_d.rdata = 32'h00000000;
                s_d.rresp = acm_pkg::RESP_SLVERR;
            end
        end else if (s_q.rvalid && s_axi_rready) begin
            s_d.rvalid = 1'b0;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s_q <= '0;
            s_q.ctrl <= acm_pkg::CTRL_RESET;
        end else begin
            s_q <= s_d;
        end
    end

    // Settling delay restarts on each channel switch and on any control register write
    acm_delay_timer u_delay (
        .clk(clk),
        .rst(rst),
        .start(channel_switch || wr_hit),
        // A write must time the delay it has just written, not the old one
        .code(wr_hit ? merged[acm_pkg::DELAY_LSB +: 3] : delay_code),
        .busy(delay_busy)
    );

    acm_clock_select u_clk (
        .clk(clk),
        .rst(rst),
        .sel(s_q.ctrl[acm_pkg::CLKSEL_LSB +: 2]),
        .osc_enable(osc_enable),
        .clk_pin_out_en(crystal_or_clock_pin_out_en),
        .ext_clk_en(ext_clk_en),
        .xtal_en(crystal_input_pin_en)
    );

    // Ready flags are registered; handshake readies track captured state
    assign s_axi_awready = !s_q.aw_got;
    assign s_axi_wready = !s_q.w_got;
    assign s_axi_bvalid = s_q.bvalid;
    assign s_axi_bresp = s_q.bresp;
    assign s_axi_arready = !s_q.rvalid;
    assign s_axi_rvalid = s_q.rvalid;
    assign s_axi_rdata = s_q.rdata;
    assign s_axi_rresp = s_q.rresp;
    assign filter_reset = s_q.filt_rst;
    assign conversion_start = s_q.conv_start;
    assign data_ready = s_q.ready;
    assign reference_output_pin_en = s_q.ref_en;
    assign operating_mode = s_q.mode_out;
    assign processing_hold = delay_busy;
endmodule : acm_top

// File: rtl/acm_pkg.sv
// Overview of operation
// - Any control register write restarts filter, clears ready, starts
// - Register at offset 0x01, resets to 0x2000
// - Bit 15 enables reference output drive
// - Bit 13 limits output to settled rate
// - Delay field waits after channel switch
// - Mode field selects converter operating state
// - Clock source field selects master clock
// - Internal oscillator codes power the oscillator
// - Reserved bits read zero, ignore writes
package acm_pkg;
    // Register index; byte address is four times it
    localparam logic [3:0] REG_INDEX = 4'h1;
    localparam logic [7:0] CTRL_ADDR = 8'h04;
    localparam logic [7:0] STAT_ADDR = 8'h08;
    localparam logic [15:0] CTRL_RESET = 16'h2000;
    // Writable bit mask: 15, 13, 10:8, 6:4, 3:2
    localparam logic [15:0] CTRL_WMASK = 16'hA77C;
    localparam int REF_EN_BIT = 15;
    localparam int SETTLED_BIT = 13;
    localparam int DELAY_LSB = 8;
    localparam int MODE_LSB = 4;
    localparam int CLKSEL_LSB = 2;
    localparam logic [31:0] CLK_HZ = 32'd25000000;
    // Delay options in microseconds
    localparam int DELAY_US [8] = '{0, 32, 128, 320, 800, 1600, 4000, 8000};
    localparam int CYC_PER_US = CLK_HZ / 1000000;
    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;

    typedef enum logic [2:0] {
        MODE_CONT, MODE_SINGLE, MODE_STANDBY, MODE_POWERDOWN,
        MODE_INT_OFFSET, MODE_RESERVED, MODE_SYS_OFFSET, MODE_SYS_GAIN
    } acm_mode_type;

    typedef enum logic [1:0] {
        CLK_INT_OSC, CLK_INT_OSC_OUT, CLK_EXT_CLOCK, CLK_EXT_CRYSTAL
    } acm_clksel_type;
endpackage : acm_pkg

// File: rtl/acm_delay_timer.sv
`timescale 1ns/10ps
// Counts out the post-switch settling delay
module acm_delay_timer (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Control
    input wire logic start,
    input wire logic [2:0] code,
    // Status
    output logic busy
);
    typedef struct packed {
        logic [17:0] cnt;
        logic busy;
    } acm_timer_type;
    acm_timer_type s_q, s_d;

    // Load count on start, run to zero
    always_comb begin
        s_d = s_q;
        if (start) begin
            s_d.cnt = 18'(acm_pkg::DELAY_US[code] * acm_pkg::CYC_PER_US);
            s_d.busy = (acm_pkg::DELAY_US[code] != 0);
        end else if (s_q.cnt > 18'h00001) begin
            s_d.cnt = s_q.cnt - 18'h00001;
        end else begin
            s_d.cnt = 18'h00000;
            s_d.busy = 1'b0;
        end
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign busy = s_q.busy;
endmodule : acm_delay_timer

// File: rtl/acm_clock_select.sv
`timescale 1ns/10ps
// Decodes the clock source field into enables
module acm_clock_select (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Field
    input wire logic [1:0] sel,
    // Enables
    output logic osc_enable,
    output logic clk_pin_out_en,
    output logic ext_clk_en,
    output logic xtal_en
);
    typedef struct packed {
        logic osc;
        logic pin_out;
        logic ext;
        logic xtal;
    } acm_clk_type;
    acm_clk_type s_q, s_d;

    // Either internal code powers the oscillator without extra action
    always_comb begin
        s_d.osc = (sel == acm_pkg::CLK_INT_OSC) || (sel == acm_pkg::CLK_INT_OSC_OUT);
        s_d.pin_out = (sel == acm_pkg::CLK_INT_OSC_OUT);
        s_d.ext = (sel == acm_pkg::CLK_EXT_CLOCK);
        s_d.xtal = (sel == acm_pkg::CLK_EXT_CRYSTAL);
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s_q <= 4'b1000; // Reset field is 00, oscillator on
        end else begin
            s_q <= s_d;
        end
    end

    assign osc_enable = s_q.osc;
    assign clk_pin_out_en = s_q.pin_out;
    assign ext_clk_en = s_q.ext;
    assign xtal_en = s_q.xtal;
endmodule : acm_clock_select

// File: test/acm_top_monitor.sv
`timescale 1ns/10ps
// Port level checker for the control register block
module acm_mon (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Bus handshakes
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // Converter controls
    input wire logic filter_reset,
    input wire logic conversion_start,
    input wire logic data_ready,
    input wire logic reference_output_pin_en,
    input wire logic [2:0] operating_mode,
    input wire logic osc_enable,
    input wire logic crystal_or_clock_pin_out_en,
    input wire logic ext_clk_en,
    input wire logic crystal_input_pin_en
);
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    // Outputs may lag the register by a cycle, so a write covers two cycles
    sequence s_wr_done; $rose(s_axi_bvalid); endsequence
    property p_wr_restart;
        filter_reset |-> (conversion_start && !data_ready) ##0 s_wr_done;
    endproperty
    a_wr_restart: assert property (p_wr_restart) else $error("write did not restart");
    // A refused write is answered but must leave the converter running
    property p_wr_err; $rose(s_axi_bvalid) && s_axi_bresp == 2'h2 |-> !filter_reset; endproperty
    a_wr_err: assert property (p_wr_err) else $error("refused write restarted");
    property p_pulse_one; filter_reset |=> !filter_reset && !conversion_start; endproperty
    a_pulse_one: assert property (p_pulse_one) else $error("restart pulse too long");
    property p_ref_hold;
        !(s_axi_bvalid || $past(s_axi_bvalid)) |-> $stable(reference_output_pin_en);
    endproperty
    a_ref_hold: assert property (p_ref_hold) else $error("reference enable moved");
    property p_mode_chg;
        $changed(operating_mode) && !(s_axi_bvalid || $past(s_axi_bvalid)) |->
            operating_mode == 3'h2 && $past(operating_mode) == 3'h1;
    endproperty
    a_mode_chg: assert property (p_mode_chg) else $error("mode moved without write");
    property p_osc; osc_enable == !(ext_clk_en || crystal_input_pin_en); endproperty
    a_osc: assert property (p_osc) else $error("oscillator enable wrong");
    property p_clk_pin; crystal_or_clock_pin_out_en |-> osc_enable && !ext_clk_en; endproperty
    a_clk_pin: assert property (p_clk_pin) else $error("clock pin drive wrong");
    property p_rd_ans; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
    a_rd_ans: assert property (p_rd_ans) else $error("read answer late");
    property p_b_hold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp); endproperty
    a_b_hold: assert property (p_b_hold) else $error("write response dropped");
endmodule : acm_mon

// File: test/tb.sv
`timescale 1ns/10ps
// Self-checking bench for the control register block
module tb;
    logic clk = 0, rst = 1, aw_v = 0, w_v = 0, b_r = 0, ar_v = 0, r_r = 0;
    logic fo = 0, cs = 0, mc = 0, aw_r, w_r, b_v, ar_r, r_v, fr, cst, rdy, ref_en, hold;
    logic osc, pin, ext, xt;
    logic [7:0] aw_a = 8'h00, ar_a = 8'h00;
    logic [31:0] w_d = 32'h0, r_d, seed = 32'hA560;
    logic [1:0] b_rs, r_rs;
    logic [2:0] mode;
    logic [15:0] v;
    int bad_count = 0, n_checks = 0, cyc = 0, k;
    acm_top dut_u (.clk(clk), .rst(rst), .s_axi_awaddr(aw_a), .s_axi_awvalid(aw_v),
        .s_axi_awready(aw_r), .s_axi_wdata(w_d), .s_axi_wstrb(4'hF), .s_axi_wvalid(w_v),
        .s_axi_wready(w_r), .s_axi_bresp(b_rs), .s_axi_bvalid(b_v), .s_axi_bready(b_r),
        .s_axi_araddr(ar_a), .s_axi_arvalid(ar_v), .s_axi_arready(ar_r), .s_axi_rdata(r_d),
        .s_axi_rresp(r_rs), .s_axi_rvalid(r_v), .s_axi_rready(r_r), .filter_output(fo),
        .channel_switch(cs), .multi_channel(mc), .filter_reset(fr), .conversion_start(cst),
        .data_ready(rdy), .reference_output_pin_en(ref_en), .operating_mode(mode),
        .processing_hold(hold), .osc_enable(osc), .crystal_or_clock_pin_out_en(pin),
        .ext_clk_en(ext), .crystal_input_pin_en(xt));
    // Clock and hang guard
    always #20 clk = ~clk;
    always @(posedge clk) begin
        cyc++;
        if (cyc == 30000) begin
            bad_count++;
            wrap_up();
        end
    end
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr
    task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("ERROR %s exp %h got %h", nm, exp, got);
        end
    endtask : chk
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : wrap_up
    // Both channels offered together, each dropped once taken
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        aw_a <= a;
        w_d <= d;
        aw_v <= 1;
        w_v <= 1;
        b_r <= 1;
        do begin
            @(posedge clk);
            if (aw_v && aw_r) aw_v <= 0;
            if (w_v && w_r) w_v <= 0;
        end while ((aw_v && !aw_r) || (w_v && !w_r));
        do @(posedge clk); while (!b_v);
        b_r <= 0;
        chk("bresp", b_rs, er);
        // Let an edge pass so a following call never re-raises bready at once
        @(posedge clk);
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
        ar_a <= a;
        ar_v <= 1;
        r_r <= 1;
        do @(posedge clk); while (!ar_r);
        ar_v <= 0;
        do @(posedge clk); while (!r_v);
        r_r <= 0;
        chk("rresp", r_rs, er);
        chk("rdata", r_d, ed);
        @(posedge clk);
    endtask : rd
    task automatic pulse_fo(input int n);
        repeat (n) begin
            fo <= 1;
            @(posedge clk);
            fo <= 0;
            @(posedge clk);
        end
    endtask : pulse_fo
    initial begin
        repeat (16) @(posedge clk);
        rst <= 0;
        @(posedge clk);
        rd(8'h04, 32'h2000, 2'h0);
        // Random fields; reserved bits set on purpose, mode 101 avoided
        for (k = 0; k < 40; k++) begin
            seed = lfsr(seed);
            v = seed[15:0];
            if (v[6:4] == 3'h5) v[6] = 0;
            wr(8'h04, {seed[31:16], v}, 2'h0);
            @(posedge clk);
            rd(8'h04, {16'h0, v & 16'hA77C}, 2'h0);
            chk("ref", ref_en, v[15]);
            chk("mode", mode, v[6:4]);
            chk("osc", osc, !v[3]);
            chk("clkpins", {pin, ext, xt}, {v[3:2] == 2'h1, v[3:2] == 2'h2, v[3:2] == 2'h3});
        end
        $display("test random fields done");
        wr(8'h10, 32'h8000, 2'h2);
        rd(8'h10, 32'h0, 2'h2);
        rd(8'h04, {16'h0, v & 16'hA77C}, 2'h0);
        $display("test unmapped done");
        // Settled output needs three filter outputs on one channel
        wr(8'h04, 32'h2000, 2'h0);
        pulse_fo(2);
        chk("rdy2", rdy, 0);
        pulse_fo(1);
        chk("rdy3", rdy, 1);
        wr(8'h04, 32'h2000, 2'h0);
        chk("rdyclr", rdy, 0);
        mc <= 1;
        pulse_fo(1);
        chk("rdymc", rdy, 1);
        wr(8'h04, 32'h0010, 2'h0);
        pulse_fo(1);
        rd(8'h04, 32'h0020, 2'h0);
        $display("test settled done");
        // 32 us delay at 25 MHz is 800 cycles of hold
        wr(8'h04, 32'h0100, 2'h0);
        cs <= 1;
        @(posedge clk);
        cs <= 0;
        k = 0;
        do begin
            @(posedge clk);
            k++;
        end while (hold === 1'b1);
        chk("delay", k >= 799 && k <= 802, 1);
        $display("test delay done");
        // Status: no ready, no restart pulse, delay finished
        rd(8'h08, 32'h0, 2'h0);
        $display("test status done");
        wrap_up();
    end
endmodule : tb
bind acm_top acm_mon acm_mon_u (.clk(clk), .rst(rst), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_rvalid(s_axi_rvalid), .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .filter_reset(filter_reset),
    .conversion_start(conversion_start), .data_ready(data_ready),
    .reference_output_pin_en(reference_output_pin_en), .operating_mode(operating_mode),
    .osc_enable(osc_enable), .crystal_or_clock_pin_out_en(crystal_or_clock_pin_out_en),
    .ext_clk_en(ext_clk_en), .crystal_input_pin_en(crystal_input_pin_en));
